// ### verilog/hps_pkg.sv
package hps_pkg;
	localparam int          NUM_PORTS       = 8;
	localparam int          NUM_REMAP       = 2;
	localparam logic [7:0]  ADDR_CFG_BYTE3  = 8'h08;
	localparam logic [7:0]  ADDR_LINE_SWAP  = 8'hFA;
	localparam logic [7:0]  ADDR_REMAP_12   = 8'hFB;
	localparam int          REMAP_EN_BIT    = 3;
	localparam int          FIELD_P1_LSB    = 0;
	localparam int          FIELD_P2_LSB    = 4;
	localparam int          FIELD_W         = 4;
	localparam int          FIELD_RSVD_BIT  = 3;
	localparam logic [7:0]  RST_LINE_SWAP   = 8'h00;
	localparam logic [7:0]  RST_REMAP_12    = 8'h21;
	localparam logic        RST_REMAP_EN    = 1'b0;
	localparam logic [3:0]  PORT_DISABLED   = 4'h0;
	localparam logic [1:0]  SYNC_RST        = 2'h0;

	typedef struct packed {
		logic dp;
		logic dm;
	} hps_lines_t;

	typedef struct packed {
		logic       enabled;
		logic [3:0] logical;
	} hps_map_t;
endpackage

// ### verilog/hps_swap.sv
`timescale 1ns/1ps
// One port's pin swapper: transmit side registered, receive side synchronised
module hps_swap (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic              swap,
	input  wire hps_pkg::hps_lines_t core_tx,
	input  wire logic              core_oe_n,
	input  wire logic              pin_p_i,
	input  wire logic              pin_m_i,
	output logic                   pin_p_o,
	output logic                   pin_m_o,
	output logic                   pin_oe_n,
	output hps_pkg::hps_lines_t    core_rx
);
	logic [2:0]          p_sync_q, p_sync_d;
	logic [2:0]          m_sync_q, m_sync_d;
	logic                p_lvl_q, p_lvl_d;
	logic                m_lvl_q, m_lvl_d;
	logic                pin_p_d, pin_m_d, pin_oe_n_d;
	hps_pkg::hps_lines_t core_rx_d;

	always_comb begin
		p_sync_d = {p_sync_q[1:0], pin_p_i};
		m_sync_d = {m_sync_q[1:0], pin_m_i};
		// A pin level counts once the second and third stages agree
		p_lvl_d = (p_sync_q[1] == p_sync_q[2]) ? p_sync_q[2] : p_lvl_q;
		m_lvl_d = (m_sync_q[1] == m_sync_q[2]) ? m_sync_q[2] : m_lvl_q;
		if (swap) begin
			pin_p_d      = core_tx.dm;
			pin_m_d      = core_tx.dp;
			core_rx_d.dp = m_lvl_q;
			core_rx_d.dm = p_lvl_q;
		end else begin
			pin_p_d      = core_tx.dp;
			pin_m_d      = core_tx.dm;
			core_rx_d.dp = p_lvl_q;
			core_rx_d.dm = m_lvl_q;
		end
		pin_oe_n_d = core_oe_n;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			p_sync_q <= 3'h0;
			m_sync_q <= 3'h0;
			p_lvl_q  <= 1'b0;
			m_lvl_q  <= 1'b0;
			pin_p_o  <= 1'b0;
			pin_m_o  <= 1'b0;
			pin_oe_n <= 1'b1;
			core_rx  <= '0;
		end else begin
			p_sync_q <= p_sync_d;
			m_sync_q <= m_sync_d;
			p_lvl_q  <= p_lvl_d;
			m_lvl_q  <= m_lvl_d;
			pin_p_o  <= pin_p_d;
			pin_m_o  <= pin_m_d;
			pin_oe_n <= pin_oe_n_d;
			core_rx  <= core_rx_d;
		end
	end
endmodule // hps_swap

// ### verilog/hps_remap.sv
`timescale 1ns/1ps
// Turns the remap byte into per-port logical numbers and the reported count
module hps_remap (
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	input  wire logic [7:0]    remap_byte,
	input  wire logic          remap_en,
	output hps_pkg::hps_map_t  map_p1,
	output hps_pkg::hps_map_t  map_p2,
	output logic [1:0]         port_count
);
	hps_pkg::hps_map_t map_p1_d, map_p2_d;
	logic [1:0]        port_count_d;

	// Reserved codes fold to the disable code
	function automatic logic [3:0] effective(input logic [3:0] field);
		effective = field[hps_pkg::FIELD_RSVD_BIT] ? hps_pkg::PORT_DISABLED : field;
	endfunction

	always_comb begin
		if (remap_en) begin
			map_p1_d.logical = effective(
				remap_byte[hps_pkg::FIELD_P1_LSB +: hps_pkg::FIELD_W]);
			map_p2_d.logical = effective(
				remap_byte[hps_pkg::FIELD_P2_LSB +: hps_pkg::FIELD_W]);
		end else begin
			map_p1_d.logical = 4'h1;
			map_p2_d.logical = 4'h2;
		end
		map_p1_d.enabled = (map_p1_d.logical != hps_pkg::PORT_DISABLED);
		map_p2_d.enabled = (map_p2_d.logical != hps_pkg::PORT_DISABLED);
		// The count leaves the hub together with the map_p1 and map_p2 logical numbers
		port_count_d = {1'b0, map_p1_d.enabled} + {1'b0, map_p2_d.enabled};
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			map_p1     <= '0;
			map_p2     <= '0;
			port_count <= 2'h0;
		end else begin
			map_p1     <= map_p1_d;
			map_p2     <= map_p2_d;
			port_count <= port_count_d;
		end
	end
endmodule // hps_remap

// ### verilog/hps_top.sv
`timescale 1ns/1ps
// Pin swap and port remap configuration for the hub.
// Configuration bytes arrive on a byte-wide write/read port driven by the
// loader that walks the EEPROM image or serves the SMBus slave.
module hps_top (
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	input  wire logic                     cfg_wr_en,
	input  wire logic                     cfg_rd_en,
	input  wire logic [7:0]               cfg_addr,
	input  wire logic [7:0]               cfg_wr_data,
	output logic [7:0]                    cfg_rd_data_q,
	input  wire hps_pkg::hps_lines_t [7:0] core_tx,
	input  wire logic [7:0]               core_oe_n,
	output hps_pkg::hps_lines_t [7:0]     core_rx,
	input  wire logic [7:0]               pin_p_i,
	input  wire logic [7:0]               pin_m_i,
	output logic [7:0]                    pin_p_o,
	output logic [7:0]                    pin_m_o,
	output logic [7:0]                    pin_oe_n,
	output hps_pkg::hps_map_t             map_p1,
	output hps_pkg::hps_map_t             map_p2,
	output logic [1:0]                    port_count
);
	logic [7:0] line_swap_q, line_swap_d;
	logic [7:0] remap_q, remap_d;
	logic       remap_en_q, remap_en_d;
	logic [7:0] rd_data_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	always_comb begin
		line_swap_d = line_swap_q;
		remap_d     = remap_q;
		remap_en_d  = remap_en_q;
		if (cfg_wr_en) begin
			if (hit(cfg_addr, hps_pkg::ADDR_LINE_SWAP))
				line_swap_d = cfg_wr_data;
			if (hit(cfg_addr, hps_pkg::ADDR_REMAP_12))
				remap_d = cfg_wr_data;
			if (hit(cfg_addr, hps_pkg::ADDR_CFG_BYTE3))
				remap_en_d = cfg_wr_data[hps_pkg::REMAP_EN_BIT];
		end
		// Unmapped reads return zero, other bits of byte 3 live elsewhere
		rd_data_d = 8'h00;
		if (cfg_rd_en) begin
			if (hit(cfg_addr, hps_pkg::ADDR_LINE_SWAP))
				rd_data_d = line_swap_q;
			else if (hit(cfg_addr, hps_pkg::ADDR_REMAP_12))
				rd_data_d = remap_q;
			else if (hit(cfg_addr, hps_pkg::ADDR_CFG_BYTE3))
				rd_data_d[hps_pkg::REMAP_EN_BIT] = remap_en_q;
		end else begin
			rd_data_d = cfg_rd_data_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			line_swap_q   <= hps_pkg::RST_LINE_SWAP;
			remap_q       <= hps_pkg::RST_REMAP_12;
			remap_en_q    <= hps_pkg::RST_REMAP_EN;
			cfg_rd_data_q <= 8'h00;
		end else begin
			line_swap_q   <= line_swap_d;
			remap_q       <= remap_d;
			remap_en_q    <= remap_en_d;
			cfg_rd_data_q <= rd_data_d;
		end
	end

	// Index 0 is the upstream port, index n is downstream port n
	for (genvar i = 0; i < hps_pkg::NUM_PORTS; i++) begin : g_port
		hps_swap u_swap (
			.clk_sys   (clk_sys),
			.reset_n   (reset_n),
			.swap      (line_swap_q[i]),
			.core_tx   (core_tx[i]),
			.core_oe_n (core_oe_n[i]),
			.pin_p_i   (pin_p_i[i]),
			.pin_m_i   (pin_m_i[i]),
			.pin_p_o   (pin_p_o[i]),
			.pin_m_o   (pin_m_o[i]),
			.pin_oe_n  (pin_oe_n[i]),
			.core_rx   (core_rx[i])
		);
	end

	hps_remap u_remap (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.remap_byte (remap_q),
		.remap_en   (remap_en_q),
		.map_p1     (map_p1),
		.map_p2     (map_p2),
		.port_count (port_count)
	);
endmodule // hps_top

// ### sim/hps_line_loop.sv
`timescale 1ns/1ps
// Pin loopback; a released pair falls to the pull-down level, not the last value
module hps_line_loop (
	input  wire logic [7:0] pin_p_o,
	input  wire logic [7:0] pin_m_o,
	input  wire logic [7:0] pin_oe_n,
	output logic [7:0]      pin_p_i,
	output logic [7:0]      pin_m_i
);
	assign pin_p_i = pin_p_o & ~pin_oe_n;
	assign pin_m_i = pin_m_o & ~pin_oe_n;
endmodule // hps_line_loop

// ### sim/hps_top_assertions.sv
`timescale 1ns/1ps
module hps_top_checker (
	input wire logic                      clk_sys,
	input wire logic                      reset_n,
	input wire logic                      cfg_wr_en,
	input wire logic                      cfg_rd_en,
	input wire logic [7:0]                cfg_addr,
	input wire logic [7:0]                cfg_wr_data,
	input wire logic [7:0]                cfg_rd_data_q,
	input wire hps_pkg::hps_lines_t [7:0] core_tx,
	input wire logic [7:0]                pin_p_o,
	input wire logic [7:0]                pin_m_o,
	input wire hps_pkg::hps_map_t         map_p1,
	input wire hps_pkg::hps_map_t         map_p2,
	input wire logic [1:0]                port_count
);
	logic [7:0]        sh_q, rm_q, dp, dm;
	logic              en_q;
	logic [1:0]        up_q;
	hps_pkg::hps_map_t e1, e2;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	function automatic hps_pkg::hps_map_t ex(logic [3:0] f, logic on, logic [3:0] d);
		return on ? {f != 4'h0 && !f[3], f} : {1'b1, d};
	endfunction
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			dp[i] = core_tx[i].dp;
			dm[i] = core_tx[i].dm;
		end
		e1 = ex(rm_q[3:0], en_q, 4'h1);
		e2 = ex(rm_q[7:4], en_q, 4'h2);
	end
	// Shadow of the stored bytes; up_q skips the edges that still see reset values
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= 8'h00;
			rm_q <= 8'h21;
			en_q <= 1'b0;
			up_q <= 2'h0;
		end else begin
			if (up_q != 2'h3) up_q <= up_q + 2'h1;
			if (cfg_wr_en && cfg_addr == 8'hFA) sh_q <= cfg_wr_data;
			if (cfg_wr_en && cfg_addr == 8'hFB) rm_q <= cfg_wr_data;
			if (cfg_wr_en && cfg_addr == 8'h08) en_q <= cfg_wr_data[3];
		end
	end
	tx_plus_a: assert property (up_q[1] |->
		pin_p_o == $past(sh_q & dm | ~sh_q & dp)) else $error("plus pin drive wrong");
	tx_minus_a: assert property (up_q[1] |->
		pin_m_o == $past(sh_q & dp | ~sh_q & dm)) else $error("minus pin drive wrong");
	// The shadow loads on the same edge as the stored byte, so one edge of $past covers the map register
	map_one_a: assert property (up_q[1] |-> map_p1.enabled == $past(e1.enabled)
		&& (!map_p1.enabled || map_p1.logical == $past(e1.logical))) else $error("port 1 map wrong");
	map_two_a: assert property (up_q[1] |-> map_p2.enabled == $past(e2.enabled)
		&& (!map_p2.enabled || map_p2.logical == $past(e2.logical))) else $error("port 2 map wrong");
	port_count_a: assert property (up_q[1] |->
		port_count == $past({1'b0, e1.enabled} + {1'b0, e2.enabled})) else $error("count wrong");
	swap_read_a: assert property (cfg_rd_en && cfg_addr == 8'hFA |=>
		cfg_rd_data_q == $past(sh_q)) else $error("swap readback wrong");
	remap_read_a: assert property (cfg_rd_en && cfg_addr == 8'hFB |=>
		cfg_rd_data_q == $past(rm_q)) else $error("remap readback wrong");
	enable_read_a: assert property (cfg_rd_en && cfg_addr == 8'h08 |=>
		cfg_rd_data_q == {4'h0, $past(en_q), 3'h0}) else $error("enable readback wrong");
endmodule // hps_top_checker
bind hps_top hps_top_checker hps_top_checker_inst (.clk_sys, .reset_n, .cfg_wr_en, .cfg_rd_en,
	.cfg_addr, .cfg_wr_data, .cfg_rd_data_q, .core_tx, .pin_p_o, .pin_m_o, .map_p1, .map_p2,
	.port_count);

// ### sim/usb_hub_pin_swap_port_remap_bench.sv
`timescale 1ns/1ps
module usb_hub_pin_swap_port_remap_bench;
	logic                      clk_sys = 1'b0, reset_n = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
	logic [7:0]                cfg_addr = 8'h00, cfg_wr_data = 8'h00, core_oe_n = 8'hFF;
	logic [7:0]                cfg_rd_data_q, pin_p_i, pin_m_i, pin_p_o, pin_m_o, pin_oe_n;
	hps_pkg::hps_lines_t [7:0] core_tx = 16'h0000, core_rx;
	hps_pkg::hps_map_t         map_p1, map_p2;
	logic [1:0]                port_count;
	logic [7:0]                sw, rm, ep, em;
	logic [7:0]                cor [8] = '{8'h00, 8'h77, 8'h88, 8'hF1, 8'h16, 8'h21,
		8'h12, 8'h01};
	logic [15:0]               er, e1, e2;
	logic [1:0]                over;
	logic                      en;
	int                        failures = 0, n_tests = 0, cyc = 0;
	always #10 clk_sys = ~clk_sys;
	hps_top hps_top_inst (.clk_sys, .reset_n, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wr_data,
		.cfg_rd_data_q, .core_tx, .core_oe_n, .core_rx, .pin_p_i, .pin_m_i, .pin_p_o, .pin_m_o,
		.pin_oe_n, .map_p1, .map_p2, .port_count);
	hps_line_loop hps_line_loop_inst (.pin_p_o, .pin_m_o, .pin_oe_n, .pin_p_i, .pin_m_i);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (failures == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{cfg_wr_en, cfg_addr, cfg_wr_data} = {1'b1, a, d};
		@(negedge clk_sys);
		cfg_wr_en = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		{cfg_rd_en, cfg_addr} = {1'b1, a};
		@(negedge clk_sys);
		cfg_rd_en = 1'b0;
		chk({8'h00, cfg_rd_data_q}, {8'h00, exp});
	endtask
	// Disabled ports have no defined logical number, so it is compared as zero
	function automatic logic [15:0] mx(logic [3:0] f, logic on, logic [3:0] d);
		if (!on) return {11'h000, 1'b1, d};
		return (f == 4'h0 || f[3]) ? 16'h0000 : {11'h000, 1'b1, f};
	endfunction
	// Only a contiguous numbering from 1 lets the host view be checked
	function automatic logic contig(logic [15:0] x1, logic [15:0] x2);
		logic [3:0] n;
		n = 4'(x1[4]) + 4'(x2[4]);
		return (!x1[4] || x1[3:0] <= n) && (!x2[4] || x2[3:0] <= n)
			&& !(x1[4] && x2[4] && x1[3:0] == x2[3:0]);
	endfunction
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(32'h69C8));
		repeat (16) @(negedge clk_sys);
		reset_n = 1'b1;
		rd(8'hFA, 8'h00);
		rd(8'hFB, 8'h21);
		for (int i = 0; i < 24; i++) begin
			sw = 8'($urandom);
			rm = (i < 8) ? cor[i] : 8'($urandom);
			en = (i < 8) || $urandom % 2;
			wr(8'hFA, sw);
			wr(8'hFB, rm);
			wr(8'h08, {4'hA, en, 3'h5});
			wr(8'h55, 8'($urandom));
			core_tx = 16'($urandom);
			core_oe_n = 8'($urandom);
			repeat (8) @(negedge clk_sys);
			rd(8'hFA, sw);
			rd(8'hFB, rm);
			rd(8'h08, {4'h0, en, 3'h0});
			rd(8'h55, 8'h00);
			for (int j = 0; j < 8; j++) begin
				ep[j] = sw[j] ? core_tx[j].dm : core_tx[j].dp;
				em[j] = sw[j] ? core_tx[j].dp : core_tx[j].dm;
				er[2*j +: 2] = core_oe_n[j] ? 2'h0 : core_tx[j];
			end
			chk({8'h00, pin_p_o}, {8'h00, ep});
			chk({8'h00, pin_m_o}, {8'h00, em});
			chk({8'h00, pin_oe_n}, {8'h00, core_oe_n});
			chk(core_rx, er);
			e1 = mx(rm[3:0], en, 4'h1);
			e2 = mx(rm[7:4], en, 4'h2);
			chk({11'h000, map_p1.enabled, map_p1.enabled ? map_p1.logical : 4'h0}, e1);
			chk({11'h000, map_p2.enabled, map_p2.enabled ? map_p2.logical : 4'h0}, e2);
			chk({14'h0000, port_count}, 16'(e1[4]) + 16'(e2[4]));
			if (contig(e1, e2)) begin
				over = {map_p1.enabled && map_p1.logical > {2'h0, port_count},
					map_p2.enabled && map_p2.logical > {2'h0, port_count}};
				chk({14'h0000, over}, 16'h0000);
			end
		end
		stop_test;
	end
endmodule // usb_hub_pin_swap_port_remap_bench
